// file: design/aspc_pkg.sv
// Package for the audio serial port clock and configuration block.
// Assumes a 32-bit APB master; register byte address is index times four.
package aspc_pkg;
	// Register indexes as printed; byte address = 4 * index
	localparam logic [7:0] IDX_CLK_SEL	= 8'h19;
	localparam logic [7:0] IDX_M_DIV	= 8'h1a;
	localparam logic [7:0] IDX_FMT	= 8'h1b;
	localparam logic [7:0] IDX_OFFS	= 8'h1c;
	localparam logic [7:0] IDX_CTL2	= 8'h1d;
	localparam logic [7:0] IDX_N_DIV	= 8'h1e;
	localparam logic [7:0] IDX_SEC1	= 8'h1f;
	localparam logic [7:0] IDX_SEC2	= 8'h20;
	localparam logic [7:0] IDX_RX_DATA	= 8'h30;
	localparam logic [7:0] IDX_STATUS	= 8'h31;

	// Reset values
	localparam logic [7:0] RST_DIV	= 8'h01;
	localparam logic [7:0] RST_ZERO	= 8'h00;

	// Divide ratio used for a zero field
	localparam logic [7:0] DIV_ZERO_RATIO	= 8'h80;

	// Frame formats
	localparam logic [1:0] FMT_I2S	= 2'b00;
	localparam logic [1:0] FMT_DSP	= 2'b01;
	localparam logic [1:0] FMT_RIGHT	= 2'b10;
	localparam logic [1:0] FMT_LEFT	= 2'b11;

	// Secondary pin source codes
	localparam logic [2:0] SRC_GP1	= 3'b000;
	localparam logic [2:0] SRC_DOUT	= 3'b011;
	localparam logic [1:0] DIN_GP1	= 2'b00;

	// Word lengths in bits
	localparam logic [5:0] WL_16	= 6'd16;
	localparam logic [5:0] WL_20	= 6'd20;
	localparam logic [5:0] WL_24	= 6'd24;
	localparam logic [5:0] WL_32	= 6'd32;

	typedef struct packed {
		logic		en;
		logic [6:0]	ratio;
	} aspc_div_t;

	typedef struct packed {
		logic [1:0]	fmt;
		logic [1:0]	wlen;
		logic		bclk_out;
		logic		wclk_out;
		logic		rsvd;
		logic		hiz;
	} aspc_fmt_t;

	typedef struct packed {
		logic [1:0]	rsvd;
		logic		din_loop;
		logic		adc_loop;
		logic		bclk_inv;
		logic		keep_alive;
		logic [1:0]	bdiv_sel;
	} aspc_ctl2_t;

	typedef struct packed {
		logic [2:0]	bclk_src;
		logic [2:0]	wclk_src;
		logic [1:0]	din_src;
	} aspc_sec1_t;

	typedef struct packed {
		logic [2:0]	adcw_src;
		logic		rsvd;
		logic		bclk_sec;
		logic		wclk_sec;
		logic		adcw_sep;
		logic		din_sec;
	} aspc_sec2_t;

	typedef struct packed {
		logic [2:0]	cksel;
		aspc_div_t	m;
		aspc_fmt_t	fmt;
		logic [7:0]	offs;
		aspc_ctl2_t	c2;
		aspc_div_t	n;
		aspc_sec1_t	s1;
		aspc_sec2_t	s2;
	} aspc_regs_t;

	// Word length code to bit count
	function automatic logic [5:0] aspc_wlen(input logic [1:0] code);
		case (code)
			2'b00:	 return WL_16;
			2'b01:	 return WL_20;
			2'b10:	 return WL_24;
			default: return WL_32;
		endcase
	endfunction : aspc_wlen
endpackage : aspc_pkg

// file: design/aspc_top.sv
// Audio serial port: clock dividers, pin routing, framing and APB registers.
// Assumes all clock pins are slow, synchronous levels sampled by pclk.
//
// Behaviour
// RULE1: M divider off while its enable bit is 0, on while 1.
// RULE2: Clock output divides by M 1..127; zero field means 128.
// RULE3: Format field: 00 I2S, 01 DSP, 10 right, 11 left justified; code frames 10 the same as 11, left justified.
// RULE4: Word length field: 16, 20, 24 or 32 bits.
// RULE5: Bit clock is input when direction bit is 0, driven when 1.
// RULE6: Word clock is input when direction bit is 0, driven when 1.
// RULE7: With high-impedance bit set, data output floats outside the data slot; code drives it with loopback set unless the pin is a secondary source.
// RULE8: Data slot delayed by 0..255 bit clocks from word clock edge.
// RULE9: Data input loops straight to data output when loopback bit set.
// RULE10: ADC data feeds the DAC path when ADC loopback bit set.
// RULE11: Inversion bit flips polarity of primary and secondary bit clock.
// RULE12: Keep-alive bit keeps generated clocks running while codec is down.
// RULE13: Bit divider input picks DAC or ADC processing or modulator clock.
// RULE14: N divider off while its enable bit is 0, on while 1.
// RULE15: Bit clock divides by N 1..127; zero field means 128.
// RULE16: Secondary bit clock from general pin one or data output pin.
// RULE17: Secondary word clock from general pin one or data output pin.
// RULE18: Secondary data input comes from general pin one.
// RULE19: Separate ADC word clock comes from general pin one.
// RULE20: Select bit picks primary or secondary bit clock for logic and generator.
// RULE21: Select bits pick primary or secondary word clock and data input.
// RULE22: ADC word clock is the DAC word clock unless separate source chosen.
// RULE23: Clock output divider input selected by three-bit source code.
// RULE24: Output bit clock is the selected divider input divided by N.
`timescale 1ns/1ps

// Clock divider driven by edges of a slow source level
module aspc_div (
	// Clock and reset
	input	wire logic		pclk,
	input	wire logic		presetn,
	input	wire logic		clk_en,
	// Source and setting
	input	wire logic		src,
	input	wire logic		en,
	input	wire logic [6:0]	ratio,
	// Divided clock
	output	logic			clk_o
);
	import aspc_pkg::*;

	logic		src_q;
	logic [6:0]	cnt;
	logic [6:0]	next_cnt;
	logic		out_q;
	logic		next_out;
	logic [7:0]	div;

	// RULE2 zero means 128
	assign div = (ratio == 7'h00) ? DIV_ZERO_RATIO : {1'b0, ratio};

	// Count source rising edges, high for first half
	always_comb begin
		next_cnt = cnt;
		next_out = out_q;
		if (!en) begin
			next_cnt = 7'h00;
			next_out = 1'b0;
		end else if ({1'b0, cnt} >= div) begin
			// Ratio cut below the count: restart the period
			next_cnt = 7'h00;
		end else if (src && !src_q) begin
			next_cnt = ({1'b0, cnt} + 8'h01 >= div) ? 7'h00 : cnt + 7'h01;
			next_out = ({1'b0, next_cnt} < {1'b0, div[7:1]});
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= 1'b0;
			cnt <= 7'h00;
			out_q <= 1'b0;
		end else if (clk_en) begin
			src_q <= src;
			cnt <= next_cnt;
			out_q <= next_out;
		end
	end

	// RULE1 enable gates output
	// Ratio one passes the source itself, so no edge is lost
	assign clk_o = en & ((div == 8'h01) ? src : out_q);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ratio;
		en |=> ({1'b0, cnt} < $past(div));
	endproperty
	a_ratio: assert property (p_ratio) else $error("divider count passed ratio"); // RULE2

	property p_off;
		!en |-> !clk_o;
	endproperty
	a_off: assert property (p_off) else $error("powered-down divider toggles"); // RULE14
endmodule : aspc_div

// Slot timer: start on word clock edge, delay, then data bits
module aspc_slot (
	// Clock and reset
	input	wire logic		pclk,
	input	wire logic		presetn,
	input	wire logic		clk_en,
	// Timing inputs
	input	wire logic		tick,
	input	wire logic		wclk,
	input	wire logic [1:0]	fmt,
	input	wire logic [7:0]	offs,
	input	wire logic [5:0]	wlen,
	// Slot state
	output	logic			in_slot,
	output	logic			last,
	output	logic [6:0]		pos
);
	import aspc_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_DATA} aspc_slot_st_t;

	aspc_slot_st_t	st;
	aspc_slot_st_t	next_st;
	logic [8:0]	cnt;
	logic [8:0]	next_cnt;
	logic [6:0]	next_pos;
	logic		wclk_q;
	logic		start;
	logic [8:0]	dly;
	logic [6:0]	len;

	// RULE8 DSP counts from rising edge
	assign start = (fmt == FMT_DSP) ? (wclk & ~wclk_q) : (wclk ^ wclk_q);
	// RULE3 I2S adds one bit delay
	assign dly = {1'b0, offs} + ((fmt == FMT_I2S) ? 9'h001 : 9'h000);
	// RULE4 DSP carries both words back to back
	assign len = (fmt == FMT_DSP) ? {wlen, 1'b0} : {1'b0, wlen};

	// RULE8 delay then data
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_pos = pos;
		if (start) begin
			next_cnt = 9'h000;
			next_pos = 7'h00;
			next_st = (dly == 9'h000) ? ST_DATA : ST_DELAY;
		end else if ((st == ST_DELAY) && (cnt >= dly)) begin
			// Offset cut mid-delay: open the slot at once
			next_st = ST_DATA;
		end else if (tick) begin
			case (st)
				ST_DELAY: begin
					next_cnt = cnt + 9'h001;
					if (cnt + 9'h001 >= dly)
						next_st = ST_DATA;
				end
				ST_DATA: begin
					next_pos = pos + 7'h01;
					if (pos + 7'h01 >= len)
						next_st = ST_IDLE;
				end
				default: next_st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_IDLE;
			cnt <= 9'h000;
			pos <= 7'h00;
			wclk_q <= 1'b0;
		end else if (clk_en) begin
			st <= next_st;
			cnt <= next_cnt;
			pos <= next_pos;
			wclk_q <= wclk;
		end
	end

	assign in_slot = (st == ST_DATA);
	assign last = in_slot && (pos == len - 7'h01);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_start_now;
		clk_en && start && (dly == 9'h000);
	endsequence

	property p_zero;
		s_start_now |=> in_slot && (pos == 7'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero offset slot late"); // RULE8

	property p_dly;
		(st == ST_DELAY) |-> (cnt < $past(dly));
	endproperty
	a_dly: assert property (p_dly) else $error("slot delay overran"); // RULE8
endmodule : aspc_slot

// Top: APB registers, clock routing and serial data paths
module aspc_top
	import aspc_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock, reset, enable
	input	wire logic			pclk,
	input	wire logic			presetn,
	input	wire logic			clk_en,
	// APB slave
	input	wire logic [ADDR_W-1:0]	paddr,
	input	wire logic			psel,
	input	wire logic			penable,
	input	wire logic			pwrite,
	input	wire logic [31:0]		pwdata,
	output	logic [31:0]			prdata,
	output	logic				pready,
	output	logic				pslverr,
	// Serial pins
	input	wire logic			bclk_in,
	output	logic				bclk_out,
	output	logic				bclk_oe_n,
	input	wire logic			wclk_in,
	output	logic				wclk_out,
	output	logic				wclk_oe_n,
	input	wire logic			din_pin,
	input	wire logic			dout_in,
	output	logic				dout_out,
	output	logic				dout_oe_n,
	input	wire logic			general_pin_one,
	input	wire logic			mclk_pin,
	output	logic				clock_output_pin,
	// On-chip clocks and power
	input	wire logic			pll_clk,
	input	wire logic			dac_proc_clock,
	input	wire logic			dac_modulator_clock,
	input	wire logic			adc_proc_clock,
	input	wire logic			adc_modulator_clock,
	input	wire logic			codec_pwr_dn,
	output	logic				clock_generator_bclk,
	// Audio data
	input	wire logic [31:0]		adc_data,
	output	logic [31:0]			dac_data,
	output	logic				dac_valid
);
	aspc_regs_t	regs;
	aspc_regs_t	next_regs;
	logic [31:0]	rd_word;
	logic [31:0]	next_prdata;
	logic		hit;
	logic		wr;
	logic [ADDR_W-3:0] widx;
	logic [7:0]	cdiv_src;
	logic [3:0]	bdiv_src;
	logic		gen_bclk;
	logic		run;
	logic		sec_bclk;
	logic		sec_wclk;
	logic		sec_din;
	logic		prim_bclk;
	logic		prim_wclk;
	logic		bclk_sel;
	logic		bclk_i;
	logic		wclk_i;
	logic		din_i;
	logic		adc_wclk;
	logic		bclk_q;
	logic		rise;
	logic		fall;
	logic [5:0]	wl;
	logic [6:0]	wcnt;
	logic [6:0]	next_wcnt;
	logic		gen_wclk;
	logic		next_gen_wclk;
	logic		tx_slot;
	logic		rx_slot;
	logic		rx_last;
	logic [6:0]	tx_pos;
	logic [5:0]	tx_p;
	logic [4:0]	tx_idx;
	logic		dout_as_in;
	logic [31:0]	rx_sh;
	logic [31:0]	next_rx_sh;
	logic [31:0]	next_dac_data;
	logic		next_dac_valid;
	logic		next_dout;

	// Zero-wait slave; unmapped access answers with an error
	assign widx = paddr[ADDR_W-1:2];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign wr = psel && penable && pwrite && hit;

	// Read mux and address decode
	always_comb begin
		rd_word = 32'h0000_0000;
		hit = (paddr[1:0] == 2'b00);
		case (widx)
			(ADDR_W-2)'(IDX_CLK_SEL): rd_word[2:0] = regs.cksel;
			(ADDR_W-2)'(IDX_M_DIV):   rd_word[7:0] = regs.m;
			(ADDR_W-2)'(IDX_FMT):     rd_word[7:0] = regs.fmt;
			(ADDR_W-2)'(IDX_OFFS):    rd_word[7:0] = regs.offs;
			(ADDR_W-2)'(IDX_CTL2):    rd_word[7:0] = regs.c2;
			(ADDR_W-2)'(IDX_N_DIV):   rd_word[7:0] = regs.n;
			(ADDR_W-2)'(IDX_SEC1):    rd_word[7:0] = regs.s1;
			(ADDR_W-2)'(IDX_SEC2):    rd_word[7:0] = regs.s2;
			(ADDR_W-2)'(IDX_RX_DATA): rd_word = dac_data;
			(ADDR_W-2)'(IDX_STATUS):
				rd_word[4:0] = {run, tx_slot, rx_slot, gen_wclk, gen_bclk};
			default: hit = 1'b0;
		endcase
	end

	// Register writes take effect at the access edge
	always_comb begin
		next_regs = regs;
		next_prdata = (psel && !penable) ? (hit ? rd_word : 32'h0000_0000) : prdata;
		if (wr) begin
			case (widx)
				(ADDR_W-2)'(IDX_CLK_SEL): next_regs.cksel = pwdata[2:0];
				(ADDR_W-2)'(IDX_M_DIV):   next_regs.m = pwdata[7:0];
				(ADDR_W-2)'(IDX_FMT):     next_regs.fmt = pwdata[7:0];
				(ADDR_W-2)'(IDX_OFFS):    next_regs.offs = pwdata[7:0];
				(ADDR_W-2)'(IDX_CTL2):    next_regs.c2 = pwdata[7:0];
				(ADDR_W-2)'(IDX_N_DIV):   next_regs.n = pwdata[7:0];
				(ADDR_W-2)'(IDX_SEC1):    next_regs.s1 = pwdata[7:0];
				(ADDR_W-2)'(IDX_SEC2):    next_regs.s2 = pwdata[7:0];
				default: next_regs = regs;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs <= '{cksel: 3'b000, m: RST_DIV, fmt: RST_ZERO, offs: RST_ZERO,
				c2: RST_ZERO, n: RST_DIV, s1: RST_ZERO, s2: RST_ZERO};
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			regs <= next_regs;
			prdata <= next_prdata;
		end
	end

	// RULE23 output divider source
	assign cdiv_src = {adc_modulator_clock, adc_proc_clock, dac_modulator_clock,
		dac_proc_clock, pll_clk, din_pin, bclk_in, mclk_pin};

	// RULE1 M divider
	aspc_div u_mdiv (
		.pclk		(pclk),
		.presetn	(presetn),
		.clk_en		(clk_en),
		.src		(cdiv_src[regs.cksel]),
		.en		(regs.m.en),
		.ratio		(regs.m.ratio),
		.clk_o		(clock_output_pin)
	);

	// RULE13 bit divider source
	assign bdiv_src = {adc_modulator_clock, adc_proc_clock, dac_modulator_clock,
		dac_proc_clock};

	// RULE14 RULE15 RULE24 N divider makes bit clock
	aspc_div u_ndiv (
		.pclk		(pclk),
		.presetn	(presetn),
		.clk_en		(clk_en),
		.src		(bdiv_src[regs.c2.bdiv_sel]),
		.en		(regs.n.en),
		.ratio		(regs.n.ratio),
		.clk_o		(gen_bclk)
	);

	// RULE12 keep-alive over power-down
	assign run = !codec_pwr_dn || regs.c2.keep_alive;

	// RULE5 bit clock direction
	assign bclk_oe_n = !regs.fmt.bclk_out;
	assign bclk_out = regs.fmt.bclk_out && gen_bclk && run;
	assign prim_bclk = regs.fmt.bclk_out ? (gen_bclk && run) : bclk_in;

	// RULE6 word clock direction
	assign wclk_oe_n = !regs.fmt.wclk_out;
	assign wclk_out = regs.fmt.wclk_out && gen_wclk && run;
	assign prim_wclk = regs.fmt.wclk_out ? (gen_wclk && run) : wclk_in;

	// RULE16 secondary bit clock pin
	assign sec_bclk = (regs.s1.bclk_src == SRC_GP1) ? general_pin_one :
		(regs.s1.bclk_src == SRC_DOUT) ? dout_in : 1'b0;
	// RULE17 secondary word clock pin
	assign sec_wclk = (regs.s1.wclk_src == SRC_GP1) ? general_pin_one :
		(regs.s1.wclk_src == SRC_DOUT) ? dout_in : 1'b0;
	// RULE18 secondary data pin
	assign sec_din = (regs.s1.din_src == DIN_GP1) && general_pin_one;

	// RULE20 bit clock for logic and generator
	assign bclk_sel = regs.s2.bclk_sec ? sec_bclk : prim_bclk;
	assign clock_generator_bclk = bclk_sel;
	// RULE11 inversion covers both pins
	assign bclk_i = bclk_sel ^ regs.c2.bclk_inv;
	// RULE21 word clock and data select
	assign wclk_i = regs.s2.wclk_sec ? sec_wclk : prim_wclk;
	assign din_i = regs.s2.din_sec ? sec_din : din_pin;
	// RULE22 RULE19 ADC word clock
	assign adc_wclk = !regs.s2.adcw_sep ? wclk_i :
		((regs.s2.adcw_src == SRC_GP1) && general_pin_one);

	// Bit clock edges; data shifts out on fall, samples on rise
	assign rise = bclk_i && !bclk_q;
	assign fall = !bclk_i && bclk_q;
	// RULE4 word length
	assign wl = aspc_wlen(regs.fmt.wlen);

	// Word clock generator counts bit clocks over a two-word frame
	always_comb begin
		next_wcnt = wcnt;
		next_gen_wclk = gen_wclk;
		if (!regs.fmt.wclk_out) begin
			next_wcnt = 7'h00;
			next_gen_wclk = 1'b0;
		end else if (fall) begin
			next_wcnt = (wcnt + 7'h01 == {wl, 1'b0}) ? 7'h00 : wcnt + 7'h01;
			// RULE3 frame shape per format
			case (regs.fmt.fmt)
				FMT_DSP: next_gen_wclk = (next_wcnt == 7'h00);
				FMT_I2S: next_gen_wclk = (next_wcnt >= {1'b0, wl});
				default: next_gen_wclk = (next_wcnt < {1'b0, wl});
			endcase
		end
	end

	// Transmit slot follows the ADC word clock
	aspc_slot u_tx (
		.pclk		(pclk),
		.presetn	(presetn),
		.clk_en		(clk_en),
		.tick		(fall),
		.wclk		(adc_wclk),
		.fmt		(regs.fmt.fmt),
		.offs		(regs.offs),
		.wlen		(wl),
		.in_slot	(tx_slot),
		.last		(),
		.pos		(tx_pos)
	);

	// Receive slot follows the DAC word clock
	aspc_slot u_rx (
		.pclk		(pclk),
		.presetn	(presetn),
		.clk_en		(clk_en),
		.tick		(fall),
		.wclk		(wclk_i),
		.fmt		(regs.fmt.fmt),
		.offs		(regs.offs),
		.wlen		(wl),
		.in_slot	(rx_slot),
		.last		(rx_last),
		.pos		()
	);

	// Mono ADC word repeats in the second DSP word
	assign tx_p = (tx_pos >= {1'b0, wl}) ? 6'(tx_pos - {1'b0, wl}) : tx_pos[5:0];
	assign tx_idx = 5'(6'd31 - tx_p);

	// Data output pin turns round when used as a secondary source
	assign dout_as_in = (regs.s1.bclk_src == SRC_DOUT && regs.s2.bclk_sec) ||
		(regs.s1.wclk_src == SRC_DOUT && regs.s2.wclk_sec);

	// RULE7 float outside the slot
	assign dout_oe_n = dout_as_in ||
		(regs.fmt.hiz && !tx_slot && !regs.c2.din_loop);

	// Serial data next values
	always_comb begin
		next_rx_sh = rx_sh;
		next_dac_data = dac_data;
		next_dac_valid = 1'b0;
		// RULE9 data input loop
		next_dout = regs.c2.din_loop ? din_i : (tx_slot && adc_data[tx_idx]);
		if (rise && rx_slot) begin
			next_rx_sh = {rx_sh[30:0], din_i};
			if (rx_last) begin
				next_dac_valid = 1'b1;
				// RULE10 ADC feeds DAC path
				next_dac_data = regs.c2.adc_loop ? adc_data : {rx_sh[30:0], din_i};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_q <= 1'b0;
			wcnt <= 7'h00;
			gen_wclk <= 1'b0;
			rx_sh <= 32'h0000_0000;
			dac_data <= 32'h0000_0000;
			dac_valid <= 1'b0;
			dout_out <= 1'b0;
		end else if (clk_en) begin
			bclk_q <= bclk_i;
			wcnt <= next_wcnt;
			gen_wclk <= next_gen_wclk;
			rx_sh <= next_rx_sh;
			dac_data <= next_dac_data;
			dac_valid <= next_dac_valid;
			dout_out <= next_dout;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_mdiv;
		!regs.m.en |-> !clock_output_pin;
	endproperty
	a_mdiv: assert property (p_mdiv) else $error("clock output while M off"); // RULE1

	property p_ndiv;
		!regs.n.en |-> !bclk_out;
	endproperty
	a_ndiv: assert property (p_ndiv) else $error("bit clock while N off"); // RULE14

	property p_bdir;
		!regs.fmt.bclk_out |-> bclk_oe_n && !bclk_out;
	endproperty
	a_bdir: assert property (p_bdir) else $error("bit clock driven as input"); // RULE5

	property p_wdir;
		!regs.fmt.wclk_out |-> wclk_oe_n && !wclk_out;
	endproperty
	a_wdir: assert property (p_wdir) else $error("word clock driven as input"); // RULE6

	property p_hiz;
		regs.fmt.hiz && !tx_slot && !regs.c2.din_loop |-> dout_oe_n;
	endproperty
	a_hiz: assert property (p_hiz) else $error("data out driven outside slot"); // RULE7

	property p_loop;
		clk_en && regs.c2.din_loop |=> dout_out == $past(din_i);
	endproperty
	a_loop: assert property (p_loop) else $error("loopback data mismatch"); // RULE9

	sequence s_rx_end;
		clk_en && rise && rx_slot && rx_last && regs.c2.adc_loop;
	endsequence

	property p_adcl;
		s_rx_end |=> dac_valid && (dac_data == $past(adc_data));
	endproperty
	a_adcl: assert property (p_adcl) else $error("ADC loop not on DAC path"); // RULE10

	property p_pwr;
		codec_pwr_dn && !regs.c2.keep_alive |-> !bclk_out && !wclk_out;
	endproperty
	a_pwr: assert property (p_pwr) else $error("clocks run while powered down"); // RULE12

	sequence s_fmt_wr;
		clk_en && psel && penable && pwrite && (paddr == ADDR_W'({IDX_FMT, 2'b00}));
	endsequence

	property p_fmt_wr;
		s_fmt_wr |=> regs.fmt == $past(pwdata[7:0]);
	endproperty
	a_fmt_wr: assert property (p_fmt_wr) else $error("format write lost"); // RULE3
endmodule : aspc_top

// file: tb/aspc_host.sv
// Host audio processor model: sources bit clock, word clock and data.
// Assumes device clock pins are inputs and pclk is far faster than the bit clock.
`timescale 1ns/1ps
module aspc_host
	import aspc_pkg::*;
(
	// Clock and control
	input	wire logic		pclk,
	input	wire logic		run,
	// Frame settings
	input	wire logic [1:0]	fmt,
	input	wire logic [5:0]	wl,
	input	wire logic [7:0]	offs,
	input	wire logic [31:0]	word,
	// Link pins
	output	logic			bclk = 1'b0,
	output	logic			wclk = 1'b0,
	output	logic			din = 1'b0
);
	logic [2:0]	ph = 3'h0;
	int		pos = 0;
	int		hp;
	int		d;
	int		s;

	always_comb begin
		hp = (fmt == FMT_DSP) ? 2 * wl + 16 : wl + 8;
		d = offs + ((fmt == FMT_I2S) ? 1 : 0);
	end

	always @(posedge pclk) begin
		if (!run) begin
			ph <= 3'h0;
			bclk <= 1'b0; // Clock stands still while run is low
			pos <= hp - 1;
			din <= ~din; // Released line shows no stale bit
		end else begin
			ph <= ph + 3'h1;
			if (ph == 3'h3)
				bclk <= 1'b1;
			if (ph == 3'h7) begin
				bclk <= 1'b0;
				s = (pos >= hp - 1) ? 0 : pos + 1; // Stale longer count wraps
				pos <= s;
				if (fmt == FMT_DSP)
					wclk <= (s == 0);
				else if (s == 0)
					wclk <= ~wclk;
				s = s - d;
				if (s >= 0 && s < ((fmt == FMT_DSP) ? 2 * wl : wl))
					din <= word[wl - 1 - s % wl];
				else
					din <= ~din;
			end
		end
	end
endmodule : aspc_host

// file: tb/audio_serial_port_clock_config_tb_top.sv
// Testbench for the audio serial port block: registers, dividers, framing.
// Assumes the host model in aspc_host.sv and the package under design/.
`timescale 1ns/1ps
module audio_serial_port_clock_config_tb_top
	import aspc_pkg::*;
;
	typedef struct packed {
		logic		w;
		logic [7:0]	sv;
		logic [7:0]	dv;
		logic		pd;
		logic [8:0]	ex;
	} aspc_crow_t;
	typedef struct packed {
		logic [7:0]	fr;
		logic [7:0]	of;
		logic [7:0]	c2;
		logic [7:0]	s2;
		logic [5:0]	wl;
		logic [31:0]	wd;
		logic [31:0]	ex;
	} aspc_srow_t;

	logic		pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic		pwrite = 1'b0, pd = 1'b0, run = 1'b0, dsel = 1'b0, e;
	logic		pready, pslverr, bclk_out, bclk_oe_n, wclk_out, wclk_oe_n;
	logic		dout_out, dout_oe_n, cko, dac_valid, hb, hw, hd, cgb;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0000_0000, adc_data = 32'h1357_9BDF;
	logic [31:0]	prdata, dac_data, r, hwd = 32'h0000_0000;
	logic [6:0]	ck = 7'h00;
	logic [1:0]	hf = 2'h0;
	logic [5:0]	hl = 6'h20;
	logic [7:0]	ho = 8'h00;
	int		mismatches = 0, comparisons = 0, n, k, z;
	logic [7:0]	ri [7] = '{IDX_M_DIV, IDX_FMT, IDX_OFFS, IDX_CTL2, IDX_N_DIV, IDX_SEC1, IDX_SEC2};
	aspc_crow_t	cr [14] = '{
		'{1'b0, 8'h00, 8'h82, 1'b0, 9'h100}, '{1'b0, 8'h03, 8'h84, 1'b0, 9'h040},
		'{1'b0, 8'h04, 8'h80, 1'b0, 9'h001}, '{1'b0, 8'h05, 8'h81, 1'b0, 9'h040},
		'{1'b0, 8'h06, 8'h81, 1'b0, 9'h020}, '{1'b0, 8'h07, 8'h81, 1'b0, 9'h010},
		'{1'b0, 8'h00, 8'h02, 1'b0, 9'h000}, '{1'b1, 8'h00, 8'h82, 1'b0, 9'h040},
		'{1'b1, 8'h01, 8'h81, 1'b0, 9'h040}, '{1'b1, 8'h02, 8'h81, 1'b0, 9'h020},
		'{1'b1, 8'h03, 8'h81, 1'b0, 9'h010}, '{1'b1, 8'h00, 8'h01, 1'b0, 9'h000},
		'{1'b1, 8'h00, 8'h81, 1'b1, 9'h000}, '{1'b1, 8'h04, 8'h81, 1'b1, 9'h080}};
	aspc_srow_t	sr [6] = '{
		'{8'h30, 8'h00, 8'h00, 8'h00, 6'h20, 32'hA5C3_0F96, 32'hA5C3_0F96},
		'{8'hC1, 8'h00, 8'h00, 8'h00, 6'h10, 32'h0000_3C5A, 32'h3C5A_3C5A},
		'{8'h20, 8'h02, 8'h00, 8'h00, 6'h18, 32'h00AB_CDEF, 32'hEFAB_CDEF},
		'{8'h90, 8'h03, 8'h00, 8'h01, 6'h14, 32'h000F_1234, 32'h234F_1234},
		'{8'h40, 8'h01, 8'h00, 8'h00, 6'h10, 32'h0000_9E37, 32'h9E37_9E37},
		'{8'h30, 8'h00, 8'h10, 8'h00, 6'h20, 32'h1111_2222, 32'h1357_9BDF}};

	// Pin levels from all drivers; a floating data pin toggles
	wire		bclk_w = bclk_oe_n ? hb : bclk_out;
	wire		wclk_w = wclk_oe_n ? hw : wclk_out;
	wire		dout_w = dout_oe_n ? ~ck[0] : dout_out;
	wire		din_w = dsel ? ~hd : hd;
	wire		gp1_w = dsel ? hd : ~hd;

	// Clock, and on-chip clock levels at distinct rates
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) ck <= ck + 7'h01;

	aspc_top #(.ADDR_W(12)) uut (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bclk_in(bclk_w), .bclk_out(bclk_out),
		.bclk_oe_n(bclk_oe_n), .wclk_in(wclk_w), .wclk_out(wclk_out), .wclk_oe_n(wclk_oe_n),
		.din_pin(din_w), .dout_in(dout_w), .dout_out(dout_out), .dout_oe_n(dout_oe_n),
		.general_pin_one(gp1_w), .mclk_pin(ck[1]), .clock_output_pin(cko), .pll_clk(ck[2]),
		.dac_proc_clock(ck[3]), .dac_modulator_clock(ck[4]), .adc_proc_clock(ck[5]),
		.adc_modulator_clock(ck[6]), .codec_pwr_dn(pd), .clock_generator_bclk(cgb),
		.adc_data(adc_data), .dac_data(dac_data), .dac_valid(dac_valid));

	aspc_host host (.pclk(pclk), .run(run), .fmt(hf), .wl(hl), .offs(ho), .word(hwd),
		.bclk(hb), .wclk(hw), .din(hd));

	task automatic stop_test;
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad

	// APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 64);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (t >= 64) begin
			mismatches++;
			stop_test();
		end
	endtask : apb

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, ad(i), {24'h00_0000, d});
	endtask : wr

	// Rising edges of a generated clock over a fixed window
	task automatic rises(input logic w);
		logic p;
		p = 1'b1;
		n = 0;
		repeat (2048) begin
			@(posedge pclk);
			if ((w ? bclk_out : cko) === 1'b1 && p !== 1'b1)
				n++;
			p = w ? bclk_out : cko;
		end
	endtask : rises

	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({bclk_oe_n, wclk_oe_n, dout_oe_n, cko, dac_valid}, 32'h0000_0018);
		foreach (ri[i]) begin
			apb(1'b0, ad(ri[i]), 32'h0000_0000);
			chk(r, {24'h00_0000, (ri[i] inside {IDX_M_DIV, IDX_N_DIV}) ? RST_DIV : RST_ZERO});
			apb(1'b1, ad(ri[i]), {24'hFF_FFFF, ri[i] ^ 8'h5A});
			apb(1'b0, ad(ri[i]), 32'h0000_0000);
			chk(r, {24'h00_0000, ri[i] ^ 8'h5A});
		end
		// Unmapped read and misaligned write are refused
		apb(1'b0, ad(8'h21), 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		apb(1'b1, 12'h06D, 32'h0000_00FF);
		apb(1'b0, ad(IDX_FMT), 32'h0000_0000);
		chk(r, 32'h0000_0041);
		wr(IDX_FMT, 8'h0C);
		@(posedge pclk);
		chk({bclk_oe_n, wclk_oe_n}, 32'h0000_0000);
		foreach (cr[i]) begin
			wr(cr[i].w ? IDX_CTL2 : IDX_CLK_SEL, cr[i].sv);
			wr(cr[i].w ? IDX_N_DIV : IDX_M_DIV, cr[i].dv);
			pd <= cr[i].pd;
			repeat (300) @(posedge pclk);
			rises(cr[i].w);
			// One edge of phase slack is accepted
			chk((n + 1 - cr[i].ex <= 2) ? cr[i].ex : n, cr[i].ex);
		end
		pd <= 1'b0;
		wr(IDX_SEC1, 8'h00);
		foreach (sr[i]) begin
			wr(IDX_FMT, sr[i].fr);
			wr(IDX_OFFS, sr[i].of);
			wr(IDX_CTL2, sr[i].c2);
			wr(IDX_SEC2, sr[i].s2);
			dsel <= sr[i].s2[0];
			hf <= sr[i].fr[7:6];
			hl <= sr[i].wl;
			ho <= sr[i].of;
			hwd <= sr[i].wd;
			run <= 1'b1;
			n = 0;
			k = 0;
			z = 0;
			while (n < 4 && k < 6000) begin
				@(posedge pclk);
				k++;
				if (dac_valid === 1'b1)
					n++;
				if (dout_oe_n === 1'b1)
					z++;
			end
			run <= 1'b0;
			if (k >= 6000) begin
				mismatches++;
				stop_test();
			end
			chk({bclk_oe_n, wclk_oe_n}, 32'h0000_0003);
			chk(dac_data, sr[i].ex);
			chk({31'h0000_0000, z != 0}, {31'h0000_0000, sr[i].fr[0]});
		end
		// Loopback and secondary bit clock routing, seen at mid-cycle
		wr(IDX_CTL2, 8'h20);
		wr(IDX_SEC2, 8'h08);
		repeat (2) begin
			@(negedge pclk);
			chk({31'h0000_0000, dout_out ^ din_w}, 32'h0000_0001);
			chk({31'h0000_0000, cgb ^ gp1_w}, 32'h0000_0000);
		end
		wr(IDX_SEC1, 8'h60);
		repeat (2) begin
			@(negedge pclk);
			chk({31'h0000_0000, cgb ^ dout_w}, 32'h0000_0000);
		end
		stop_test();
	end
endmodule : audio_serial_port_clock_config_tb_top
